//--- rtl/pidsel_pkg.sv
// package: constants and carrier types for the pid source and mode selector
package pidsel_pkg;
   // digital input function codes
   localparam logic [7:0] DI_PID_DISABLE   = 8'h13;
   localparam logic [7:0] DI_INT_RESET     = 8'h1E;
   localparam logic [7:0] DI_INT_HOLD      = 8'h1F;
   localparam logic [7:0] DI_SOFT_START    = 8'h22;
   localparam logic [7:0] DI_INPUT_INVERT  = 8'h23;
   // second analog input functions
   localparam logic [3:0] AI2_FEEDBACK     = 4'hB;
   localparam logic [3:0] AI2_TARGET       = 4'hC;
   // pulse input functions
   localparam logic [1:0] PI_FREQ_REF      = 2'h0;
   localparam logic [1:0] PI_FEEDBACK      = 2'h1;
   localparam logic [1:0] PI_TARGET        = 2'h2;
   // communication registers
   localparam logic [3:0] REG_COMM_TARGET  = 4'h6;
   localparam logic [3:0] REG_COMM_ENABLE  = 4'hF;
   localparam int         COMM_TGT_EN_BIT  = 1;
   localparam logic [15:0] COMM_RESET_VAL  = 16'h0000;
   // full scale percent in 0.01 % units
   localparam logic [15:0] FULL_SCALE_PCT  = 16'h2710;
   localparam int          NUM_DI          = 5;

   typedef enum logic [1:0] {PIDSEL_SRC_NONE, PIDSEL_SRC_AI2, PIDSEL_SRC_PULSE, PIDSEL_SRC_COMM} pidsel_dummy_t;

   typedef struct packed {
      logic pid_disable;
      logic int_reset;
      logic int_hold;
      logic soft_start_off;
      logic input_invert;
   } pidsel_di_t;

   typedef struct packed {
      logic direct_out;
      logic add_comp;
      logic d_on_fb;
      logic d_enable;
   } pidsel_mode_t;
endpackage : pidsel_pkg

//--- rtl/pidsel_regs.sv
// communication register pair: target value and source enable flags
`timescale 1ns/100ps
module pidsel_regs (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // host write/read port
   input  wire logic        wr_en,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   output logic      [15:0] rdata_q,
   // stored values
   output logic      [15:0] target_q,
   output logic      [15:0] flags_q
);
   wire sel_target = (addr == pidsel_pkg::REG_COMM_TARGET);
   wire sel_flags  = (addr == pidsel_pkg::REG_COMM_ENABLE);
   wire [15:0] rd_mux = sel_target ? target_q : (sel_flags ? flags_q : 16'h0000);

   // unmapped addresses read zero, writes to them are dropped
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         target_q <= pidsel_pkg::COMM_RESET_VAL;
         flags_q  <= pidsel_pkg::COMM_RESET_VAL;
         rdata_q  <= 16'h0000;
      end else begin
         if (wr_en && sel_target) target_q <= wdata;
         if (wr_en && sel_flags)  flags_q  <= wdata;
         rdata_q <= rd_mux;
      end
   end
endmodule : pidsel_regs

//--- rtl/pidsel_top.sv
// top: pid source allocation, method decode, target scaling and error flags
`timescale 1ns/100ps
module pidsel_top #(
   parameter int NUM_MON = 32
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   // multi-function digital inputs: pins and selectors
   input  wire logic [4:0]             di_pin,
   input  wire logic [4:0][7:0]        multi_function_digital_input_select,
   // source selectors
   input  wire logic [3:0]             second_analog_input_function_select,
   input  wire logic [1:0]             pulse_input_function_select,
   input  wire logic [2:0]             pid_method_select,
   input  wire logic                   target_parameter_enable,
   input  wire logic [15:0]            target_parameter_value,
   input  wire logic [7:0]             monitor_feedback_select,
   input  wire logic [15:0]            derivative_time,
   // drive events
   input  wire logic                   reset_cmd,
   input  wire logic                   drive_stop,
   // source values
   input  wire logic [15:0]            first_analog_input,
   input  wire logic [15:0]            second_analog_input,
   input  wire logic [15:0]            pulse_input,
   input  wire logic [15:0]            freq_ref_hz,
   input  wire logic [15:0]            full_scale_hz,
   input  wire logic [NUM_MON-1:0][15:0] internal_monitor_items,
   // serial host register port
   input  wire logic                   comm_wr,
   input  wire logic [3:0]             comm_addr,
   input  wire logic [15:0]            comm_wdata,
   output logic      [15:0]            comm_rdata,
   // outputs to the pid and frequency path
   output logic                        pid_enable_q,
   output logic                        int_clear_q,
   output logic                        int_hold_q,
   output logic                        soft_start_en_q,
   output logic                        input_invert_q,
   output pidsel_pkg::pidsel_mode_t    mode_q,
   output logic      [15:0]            target_pct_q,
   output logic      [15:0]            feedback_q,
   output logic                        pulse_is_freq_ref_q,
   output logic                        configuration_error_q
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [4:0] di_s1_q, di_s2_q;
   logic       rst_s1_q, rst_s2_q, stop_s1_q, stop_s2_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         di_s1_q   <= 5'h00;
         di_s2_q   <= 5'h00;
         rst_s1_q  <= 1'b0;
         rst_s2_q  <= 1'b0;
         stop_s1_q <= 1'b0;
         stop_s2_q <= 1'b0;
      end else begin
         di_s1_q   <= di_pin;
         di_s2_q   <= di_s1_q;
         rst_s1_q  <= reset_cmd;
         rst_s2_q  <= rst_s1_q;
         stop_s1_q <= drive_stop;
         stop_s2_q <= stop_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // digital input function decode, one slice per terminal
   // nets, since each generate slice drives its own bit
   wire  [4:0] on_dis, on_rst, on_hold, on_soft, on_inv, has_rst;
   genvar gi;
   generate
      for (gi = 0; gi < pidsel_pkg::NUM_DI; gi++) begin : g_di
         wire [7:0] fsel = multi_function_digital_input_select[gi];
         assign on_dis[gi]  = di_s2_q[gi] && (fsel == pidsel_pkg::DI_PID_DISABLE);
         assign has_rst[gi] = (fsel == pidsel_pkg::DI_INT_RESET);
         assign on_rst[gi]  = di_s2_q[gi] && has_rst[gi];
         assign on_hold[gi] = di_s2_q[gi] && (fsel == pidsel_pkg::DI_INT_HOLD);
         assign on_soft[gi] = di_s2_q[gi] && (fsel == pidsel_pkg::DI_SOFT_START);
         assign on_inv[gi]  = di_s2_q[gi] && (fsel == pidsel_pkg::DI_INPUT_INVERT);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // method decode
   wire meth_direct = (pid_method_select == 3'h1) || (pid_method_select == 3'h2);
   wire meth_comp   = (pid_method_select == 3'h3) || (pid_method_select == 3'h4);
   wire meth_dfb    = (pid_method_select == 3'h2) || (pid_method_select == 3'h4);
   wire d_on        = (derivative_time != 16'h0000);
   wire pid_active  = (meth_direct || meth_comp) && !(|on_dis);
   // integral clear: pin on, or reset command, or stop while pid active, with code 30 assigned
   wire int_clr     = (|on_rst) || ((|has_rst) && (rst_s2_q || (stop_s2_q && pid_active)));

   ////////////////////////////////////////////////////////////////////////////
   // communication registers
   logic [15:0] comm_target, comm_flags;
   pidsel_regs u_regs (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .wr_en    (comm_wr),
      .addr     (comm_addr),
      .wdata    (comm_wdata),
      .rdata_q  (comm_rdata),
      .target_q (comm_target),
      .flags_q  (comm_flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // source allocation
   wire tgt_ai2   = (second_analog_input_function_select == pidsel_pkg::AI2_TARGET);
   wire fb_ai2    = (second_analog_input_function_select == pidsel_pkg::AI2_FEEDBACK);
   wire tgt_pulse = (pulse_input_function_select == pidsel_pkg::PI_TARGET);
   wire fb_pulse  = (pulse_input_function_select == pidsel_pkg::PI_FEEDBACK);
   wire pulse_ref = (pulse_input_function_select == pidsel_pkg::PI_FREQ_REF);
   wire tgt_comm  = comm_flags[pidsel_pkg::COMM_TGT_EN_BIT];
   wire tgt_par   = target_parameter_enable;
   wire mon_ok    = (monitor_feedback_select != 8'h00) && (monitor_feedback_select < NUM_MON);
   wire fb_mon    = mon_ok;
   wire [2:0] n_tgt = {2'b00, tgt_ai2} + {2'b00, tgt_pulse} + {2'b00, tgt_comm} + {2'b00, tgt_par};
   wire [1:0] n_fb  = {1'b0, fb_ai2} + {1'b0, fb_pulse} + {1'b0, fb_mon};
   // recomputed every cycle, so the flag drops once the conflict is gone
   wire cfg_err   = (n_tgt > 3'h1) || (n_fb > 2'h1);

   // target selection; alternates ignored outside methods 3/4
   wire [15:0] ref_pct;
   wire [15:0] tgt_src = !meth_comp ? ref_pct :
                         tgt_ai2    ? second_analog_input :
                         tgt_pulse  ? pulse_input :
                         tgt_comm   ? comm_target :
                         tgt_par    ? target_parameter_value :
                                      ref_pct;
   // feedback: analog two, pulse, monitor, else first analog
   wire [7:0]  mon_idx = mon_ok ? monitor_feedback_select : 8'h00;
   wire [15:0] fb_src  = fb_ai2 && !tgt_ai2 ? second_analog_input :
                         fb_pulse           ? pulse_input :
                         fb_mon             ? internal_monitor_items[mon_idx] :
                                              first_analog_input;

   ////////////////////////////////////////////////////////////////////////////
   // hz to percent: full scale reads 100.00 %; division kept small by one divider
   wire [31:0] num = {16'h0000, freq_ref_hz} * {16'h0000, pidsel_pkg::FULL_SCALE_PCT};
   wire [31:0] quo = (full_scale_hz == 16'h0000) ? 32'h0000_0000 : num / {16'h0000, full_scale_hz};
   assign ref_pct  = (quo > {16'h0000, pidsel_pkg::FULL_SCALE_PCT}) ? pidsel_pkg::FULL_SCALE_PCT : quo[15:0];

   ////////////////////////////////////////////////////////////////////////////
   // output registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pid_enable_q          <= 1'b0;
         int_clear_q           <= 1'b0;
         int_hold_q            <= 1'b0;
         soft_start_en_q       <= 1'b1;
         input_invert_q        <= 1'b0;
         mode_q                <= '0;
         target_pct_q          <= 16'h0000;
         feedback_q            <= 16'h0000;
         pulse_is_freq_ref_q   <= 1'b1;
         configuration_error_q <= 1'b0;
      end else begin
         pid_enable_q          <= pid_active;
         int_clear_q           <= int_clr;
         int_hold_q            <= |on_hold;
         soft_start_en_q       <= !(|on_soft);
         input_invert_q        <= |on_inv;
         mode_q.direct_out     <= meth_direct && pid_active;
         mode_q.add_comp       <= meth_comp && pid_active;
         mode_q.d_on_fb        <= meth_dfb;
         mode_q.d_enable       <= d_on;
         target_pct_q          <= tgt_src;
         feedback_q            <= fb_src;
         pulse_is_freq_ref_q   <= pulse_ref;
         configuration_error_q <= cfg_err;
      end
   end
endmodule : pidsel_top

//--- tb/pidsel_host.sv
// host model: serial master writing and reading the communication registers
`timescale 1ns/100ps
module pidsel_host (
   // clock
   input  wire logic        sys_clk,
   // register port toward the device
   output logic             comm_wr,
   output logic      [3:0]  comm_addr,
   output logic      [15:0] comm_wdata,
   input  wire logic [15:0] comm_rdata
);
   initial begin
      comm_wr    = 1'b0;
      comm_addr  = 4'h0;
      comm_wdata = 16'h0000;
   end
   // one-cycle strobe; data inverted after so a late sample shows up
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      comm_wr    <= 1'b1;
      comm_addr  <= a;
      comm_wdata <= d;
      @(posedge sys_clk);
      comm_wr    <= 1'b0;
      comm_wdata <= ~d;
   endtask : wr
   // address held two edges: one to register it, one to take the answer
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      comm_addr <= a;
      repeat (2) @(posedge sys_clk);
      d = comm_rdata;
   endtask : rd
endmodule : pidsel_host

//--- tb/pidsel_monitor.sv
// checker: timing relations at the pid selector ports
`timescale 1ns/100ps
module pidsel_monitor (
   // clock and reset
   input wire logic                     sys_clk,
   input wire logic                     srst,
   // pins and selectors
   input wire logic [4:0]               di_pin,
   input wire logic [4:0][7:0]          multi_function_digital_input_select,
   input wire logic [3:0]               second_analog_input_function_select,
   input wire logic [1:0]               pulse_input_function_select,
   input wire logic [2:0]               pid_method_select,
   input wire logic [15:0]              derivative_time,
   // decoded outputs
   input wire logic                     pid_enable_q,
   input wire logic                     int_hold_q,
   input wire pidsel_pkg::pidsel_mode_t mode_q,
   input wire logic                     pulse_is_freq_ref_q,
   input wire logic                     configuration_error_q
);
   wire [4:0][7:0] sel  = multi_function_digital_input_select;
   wire [3:0]      ai2  = second_analog_input_function_select;
   wire [1:0]      pul  = pulse_input_function_select;
   wire [2:0]      meth = pid_method_select;
   logic [1:0]     age_q;
   // edges since reset; pin paths need three before their history is valid
   always_ff @(posedge sys_clk) begin
      if (srst) age_q <= 2'h0;
      else if (age_q != 2'h3) age_q <= age_q + 2'h1;
   end
   wire ok = (age_q == 2'h3);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////
   // direct/compensation bits only count while pid runs; a code-19 pin masks both output methods
   direct_out_a: assert property (ok && $past(meth) inside {[3'h1:3'h4]} |->
      mode_q.direct_out == (pid_enable_q && $past(meth) < 3'h3))
      else $error("direct output decode wrong");
   add_comp_a: assert property (ok && $past(meth) inside {[3'h1:3'h4]} |->
      mode_q.add_comp == (pid_enable_q && $past(meth) > 3'h2))
      else $error("compensation decode wrong");
   d_source_a: assert property (ok && $past(meth) inside {[3'h1:3'h4]} |->
      mode_q.d_on_fb == !$past(meth[0]))
      else $error("derivative source wrong");
   d_off_a: assert property (ok && $past(derivative_time) == 16'h0000 |-> !mode_q.d_enable)
      else $error("derivative not disabled");
   pulse_ref_a: assert property (ok |-> pulse_is_freq_ref_q == ($past(pul) == 2'h0))
      else $error("pulse reference decode wrong");
   tgt_dup_a: assert property (ok && $past(ai2) == 4'hC && $past(pul) == 2'h2 |-> configuration_error_q)
      else $error("duplicate target not flagged");
   fb_dup_a: assert property (ok && $past(ai2) == 4'hB && $past(pul) == 2'h1 |-> configuration_error_q)
      else $error("duplicate feedback not flagged");
   pid_off_a: assert property (ok && $past(sel[0]) == 8'h13 && $past(di_pin[0], 3) |-> !pid_enable_q)
      else $error("pid not disabled by pin");
   hold_on_a: assert property (ok && $past(sel[2]) == 8'h1F && $past(di_pin[2], 3) |-> int_hold_q)
      else $error("integral hold missing");
   cfg_err_c: cover property (configuration_error_q);
   comp_run_c: cover property (pid_enable_q && mode_q.add_comp);
   hold_c: cover property (int_hold_q);
endmodule : pidsel_monitor

bind pidsel_top pidsel_monitor u_monitor (.*);

//--- tb/pidsel_top_test.sv
// testbench: directed checks of the pid selector over pins, selectors and host registers
`timescale 1ns/100ps
module pidsel_top_test;
   logic                     sys_clk = 1'b0, srst = 1'b1, reset_cmd = 1'b0, drive_stop = 1'b0, comm_wr;
   logic                     target_parameter_enable = 1'b0, pulse_is_freq_ref_q, configuration_error_q;
   logic                     pid_enable_q, int_clear_q, int_hold_q, soft_start_en_q, input_invert_q;
   logic [4:0]               di_pin = 5'h00;
   logic [4:0][7:0]          multi_function_digital_input_select = 40'h0;
   logic [3:0]               second_analog_input_function_select = 4'h0, comm_addr;
   logic [1:0]               pulse_input_function_select = 2'h0;
   logic [2:0]               pid_method_select = 3'h0;
   logic [7:0]               monitor_feedback_select = 8'h00;
   logic [15:0]              target_parameter_value = 16'h0777, derivative_time = 16'h0064, rd;
   logic [15:0]              first_analog_input = 16'h0111, second_analog_input = 16'h0222, pulse_input = 16'h0333;
   logic [15:0]              freq_ref_hz = 16'h0BB8, full_scale_hz = 16'h1770, comm_wdata, comm_rdata;
   logic [15:0]              target_pct_q, feedback_q;
   logic [31:0][15:0]        internal_monitor_items;
   pidsel_pkg::pidsel_mode_t mode_q;
   int                       errors = 0, checked = 0;

   pidsel_top dut (.*);
   pidsel_host host (.*);
   ////////////////////////////////////////////////////////////////////////////
   initial forever #12.5 sys_clk = ~sys_clk;
   // watchdog at several times the expected run
   initial begin
      #30000;
      errors++;
      end_sim;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // outputs are levels; five edges covers the three-edge pin path
   task automatic settle;
      repeat (5) @(posedge sys_clk);
   endtask : settle
   task automatic end_sim;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 32; i++) internal_monitor_items[i] = 16'h1000 + 16'(i);
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      settle;
      chk({pid_enable_q, int_clear_q, int_hold_q, soft_start_en_q, input_invert_q, mode_q, pulse_is_freq_ref_q,
           configuration_error_q}, 16'h0086);
      host.wr(4'h6, 16'h1234);
      host.wr(4'hF, 16'h0002);
      host.wr(4'h3, 16'hFFFF);
      host.rd(4'h6, rd);
      chk(rd, 16'h1234);
      host.rd(4'hF, rd);
      chk(rd, 16'h0002);
      host.rd(4'h3, rd);
      chk(rd, 16'h0000);
      $display("test registers done");
      for (int m = 1; m < 5; m++) begin
         pid_method_select <= 3'(m);
         settle;
         chk({pid_enable_q, mode_q}, {11'h000, 1'b1, m < 3, m > 2, m[0] == 1'b0, 1'b1});
      end
      derivative_time <= 16'h0000;
      pid_method_select <= 3'h1;
      settle;
      chk(mode_q.d_enable, 1'b0);
      chk(target_pct_q, 16'h1388);
      pid_method_select <= 3'h3;
      settle;
      chk(target_pct_q, 16'h1234);
      host.wr(4'hF, 16'h0000);
      target_parameter_enable <= 1'b1;
      settle;
      chk(target_pct_q, 16'h0777);
      pulse_input_function_select <= 2'h2;
      settle;
      chk(configuration_error_q, 1'b1);
      target_parameter_enable <= 1'b0;
      settle;
      chk(configuration_error_q, 1'b0);
      chk(target_pct_q, 16'h0333);
      $display("test methods and targets done");
      pulse_input_function_select <= 2'h1;
      settle;
      chk(pulse_is_freq_ref_q, 1'b0);
      chk(feedback_q, 16'h0333);
      second_analog_input_function_select <= 4'hB;
      settle;
      chk(configuration_error_q, 1'b1);
      second_analog_input_function_select <= 4'hC;
      settle;
      chk(feedback_q, 16'h0333);
      chk(target_pct_q, 16'h0222);
      pulse_input_function_select <= 2'h0;
      second_analog_input_function_select <= 4'hB;
      settle;
      chk(feedback_q, 16'h0222);
      monitor_feedback_select <= 8'h03;
      settle;
      chk(configuration_error_q, 1'b1);
      second_analog_input_function_select <= 4'h0;
      settle;
      chk(feedback_q, 16'h1003);
      $display("test feedback done");
      multi_function_digital_input_select <= {8'h23, 8'h22, 8'h1F, 8'h1E, 8'h13};
      di_pin <= 5'h1F;
      settle;
      chk({pid_enable_q, int_clear_q, int_hold_q, soft_start_en_q, input_invert_q}, 16'h000D);
      di_pin <= 5'h00;
      settle;
      chk({pid_enable_q, int_clear_q, int_hold_q, soft_start_en_q, input_invert_q}, 16'h0012);
      reset_cmd <= 1'b1;
      settle;
      chk(int_clear_q, 1'b1);
      reset_cmd <= 1'b0;
      drive_stop <= 1'b1;
      settle;
      chk(int_clear_q, 1'b1);
      $display("test digital inputs done");
      end_sim;
   end
endmodule : pidsel_top_test
